// ### hdl/cpu_pkg.sv
`default_nettype none
package cpu_pkg;
   localparam logic [3:0]  PC_IDX       = 4'h0;
   localparam logic [3:0]  SP_IDX       = 4'h1;
   localparam logic [3:0]  SR_IDX       = 4'h2;
   localparam logic [3:0]  CG_IDX       = 4'h3;
   localparam int          NUM_REGS     = 16;
   localparam int          C_BIT        = 0;
   localparam int          Z_BIT        = 1;
   localparam int          N_BIT        = 2;
   localparam int          V_BIT        = 8;
   localparam logic [15:0] RESET_VECTOR = 16'hfffe;
   localparam logic [15:0] WORD_STEP    = 16'h0002;
   localparam logic [15:0] BYTE_STEP    = 16'h0001;
   localparam logic [15:0] BYTE_MASK    = 16'h00ff;
   localparam logic [1:0]  AM_REG       = 2'h0;
   localparam logic [1:0]  AM_IDX       = 2'h1;
   localparam logic [1:0]  AM_IND       = 2'h2;
   localparam logic [1:0]  AM_INC       = 2'h3;
   localparam logic [15:0] CG_ZERO      = 16'h0000;
   localparam logic [15:0] CG_ONE       = 16'h0001;
   localparam logic [15:0] CG_TWO       = 16'h0002;
   localparam logic [15:0] CG_FOUR      = 16'h0004;
   localparam logic [15:0] CG_EIGHT     = 16'h0008;
   localparam logic [15:0] CG_ONES      = 16'hffff;
   localparam logic [2:0]  JMP_TAG      = 3'h1;
   localparam logic [5:0]  F2_TAG       = 6'h04;
   localparam logic [2:0]  F2_PUSH      = 3'h4;
   localparam logic [2:0]  F2_CALL      = 3'h5;
   localparam logic [2:0]  F2_RETI      = 3'h6;
   localparam logic [4:0]  DEC_LIMIT    = 5'h09;
   localparam logic [4:0]  DEC_ADJ      = 5'h06;
   localparam logic [3:0]  OP_RRC = 4'h0, OP_SWPB = 4'h1, OP_RRA = 4'h2, OP_SXT = 4'h3;
   localparam logic [3:0]  OP_MOV = 4'h4, OP_ADD = 4'h5, OP_ADDC = 4'h6, OP_SUBC = 4'h7;
   localparam logic [3:0]  OP_SUB = 4'h8, OP_CMP = 4'h9, OP_DADD = 4'ha, OP_BIT = 4'hb;
   localparam logic [3:0]  OP_BIC = 4'hc, OP_BIS = 4'hd, OP_XOR = 4'he, OP_AND = 4'hf;

   typedef enum logic [2:0] {
      jump_if_not_equal = 3'h0, jump_if_equal = 3'h1, jump_if_no_carry = 3'h2,
      jump_if_carry = 3'h3, jump_if_negative = 3'h4, jump_if_ge = 3'h5,
      jump_if_less = 3'h6, jump_always = 3'h7
   } jump_cond_e;

   typedef enum logic [3:0] {
      st_vec = 4'h0, st_vload = 4'h1, st_fetch = 4'h2, st_decode = 4'h3,
      st_sext = 4'h4, st_sread = 4'h5, st_dph = 4'h6, st_dext = 4'h7,
      st_dread = 4'h8, st_exec = 4'h9, st_pop_sr = 4'ha, st_pop_pc = 4'hb
   } state_e;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        byte_en;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_s;

   typedef struct packed {
      logic        wr;
      logic        fl;
      logic [15:0] res;
      logic        c;
      logic        z;
      logic        n;
      logic        v;
   } alu_res_s;
endpackage
`default_nettype wire

// ### hdl/risc16_cpu_operand_decode.sv
// Overview of operation
// RULE1 - Sixteen 16-bit registers addressed as operands
// RULE2 - R0 PC, R1 SP, R2 status, R3 constants
// RULE3 - Register-to-register operation executes in one cycle
// RULE4 - Seven source, four destination modes, register ALU
// RULE5 - Base set of 51 instructions decoded
// RULE6 - Word or byte operation per instruction
// RULE7 - Dual-operand, single-operand and relative jump formats
// RULE8 - Call pushes PC, loads operand into PC
// RULE9 - Not-equal jump taken only when zero clear
// RULE10 - Mode validity; autoincrement adds two per word
// RULE11 - Memory and peripherals share one bus
// RULE12 - SP predecrements and postincrements by two
`timescale 1ns/1ps
`default_nettype none
module risc16_cpu_operand_decode #(
   parameter logic [15:0] RESET_VEC = cpu_pkg::RESET_VECTOR
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [15:0]       mem_rdata,
   output var  cpu_pkg::mem_req_s mem_req_q,
   output var  logic              retire_q,
   output var  logic [15:0]       cpu_status_word_q
);
   logic [15:0]       rf_q [cpu_pkg::NUM_REGS];
   cpu_pkg::state_e   st_q;
   logic [15:0]       ir_q, sv_q, dv_q, da_q;
   logic              dmem_q;
   logic [15:0]       iw, pc, rv, cgv, sbase, dbase, alu_s, alu_d, jmp_tgt, step;
   logic [3:0]        sreg, aop;
   logic [1:0]        am;
   logic              ad, bw, f1, f2, jmp, illegal, cg, needs_sext, src_reg, rr_now, take;
   logic              dst_is_reg, exec_now, wb_en, mem_wr_now, dec_src_rd, stack_op;
   logic [2:0]        f2op;
   cpu_pkg::alu_res_s alu_r;

   function automatic logic [15:0] msk(input logic [15:0] v, input logic b);
      msk = b ? (v & cpu_pkg::BYTE_MASK) : v;
   endfunction

   function automatic cpu_pkg::alu_res_s alu(input logic [3:0] op, input logic b,
                                             input logic [15:0] s, input logic [15:0] d,
                                             input logic cy);
      cpu_pkg::alu_res_s r;
      logic [16:0]       sum;
      logic [15:0]       sn, opb;
      logic [4:0]        nib;
      logic              arith, cd, cb, cl, vl;
      int                msb;
      r     = '0;
      msb   = b ? 7 : 15;
      sn    = msk(~s, b);
      opb   = s;
      sum   = '0;
      arith = 1'h0;
      cd    = cy;
      cb    = cy;
      cl    = 1'h0;
      vl    = 1'h0;
      r.wr  = 1'h1;
      r.fl  = 1'h1;
      unique case (op)
         cpu_pkg::OP_MOV:  begin r.res = s; r.fl = 1'h0; end
         cpu_pkg::OP_ADD:  begin sum = {1'h0, d} + {1'h0, s}; arith = 1'h1; end
         cpu_pkg::OP_ADDC: begin sum = {1'h0, d} + {1'h0, s} + {16'h0000, cy}; arith = 1'h1; end
         cpu_pkg::OP_SUBC: begin sum = {1'h0, d} + {1'h0, sn} + {16'h0000, cy}; arith = 1'h1; end
         cpu_pkg::OP_SUB, cpu_pkg::OP_CMP: begin
            sum   = {1'h0, d} + {1'h0, sn} + 17'h00001;
            arith = 1'h1;
            r.wr  = (op == cpu_pkg::OP_SUB);
         end
         cpu_pkg::OP_DADD: begin
            for (int k = 0; k < 4; k++) begin
               nib = {1'h0, d[4*k+:4]} + {1'h0, s[4*k+:4]} + {4'h0, cd};
               if (nib > cpu_pkg::DEC_LIMIT) begin
                  nib = nib + cpu_pkg::DEC_ADJ;
               end
               r.res[4*k+:4] = nib[3:0];
               cd = nib[4];
               if (k == 1) begin
                  cb = cd;
               end
            end
            cl = b ? cb : cd;
         end
         cpu_pkg::OP_BIT, cpu_pkg::OP_AND: begin r.res = d & s; r.wr = (op == cpu_pkg::OP_AND); end
         cpu_pkg::OP_BIC:  begin r.res = d & ~s; r.fl = 1'h0; end
         cpu_pkg::OP_BIS:  begin r.res = d | s; r.fl = 1'h0; end
         cpu_pkg::OP_XOR:  begin r.res = d ^ s; vl = s[msb] & d[msb]; end
         cpu_pkg::OP_RRC:  begin r.res = (d >> 1) | ({15'h0000, cy} << msb); cl = d[0]; end
         cpu_pkg::OP_RRA:  begin r.res = (d >> 1) | ({15'h0000, d[msb]} << msb); cl = d[0]; end
         cpu_pkg::OP_SWPB: begin r.res = {d[7:0], d[15:8]}; r.fl = 1'h0; end
         cpu_pkg::OP_SXT:  begin r.res = {{8{d[7]}}, d[7:0]}; end
      endcase
      if (op == cpu_pkg::OP_SUB || op == cpu_pkg::OP_SUBC || op == cpu_pkg::OP_CMP) begin
         opb = sn;
      end
      if (arith) begin
         r.res = sum[15:0];
         cl = b ? sum[8] : sum[16];
         vl = (opb[msb] == d[msb]) && (sum[msb] != d[msb]);
      end
      if (op != cpu_pkg::OP_SWPB && op != cpu_pkg::OP_SXT) begin
         r.res = msk(r.res, b); // [RULE6]
      end
      r.z = (msk(r.res, b) == 16'h0000);
      r.n = r.res[msb];
      if (op == cpu_pkg::OP_AND || op == cpu_pkg::OP_BIT || op == cpu_pkg::OP_XOR ||
          op == cpu_pkg::OP_SXT) begin
         cl = ~r.z;
      end
      r.c = cl;
      r.v = vl;
      return r;
   endfunction

   // During decode the word is still on the bus; afterwards it is held in ir_q
   assign iw   = (st_q == cpu_pkg::st_decode) ? mem_rdata : ir_q;
   assign pc   = rf_q[cpu_pkg::PC_IDX];
   assign f1   = (iw[15:14] != 2'h0); // [RULE7]
   assign jmp  = (iw[15:13] == cpu_pkg::JMP_TAG);
   assign f2   = (iw[15:10] == cpu_pkg::F2_TAG);
   assign f2op = iw[9:7];
   assign illegal = !(f1 || jmp || (f2 && f2op <= cpu_pkg::F2_RETI)); // [RULE5]
   assign sreg = f1 ? iw[11:8] : iw[3:0];
   assign am   = iw[5:4];
   assign ad   = iw[7];
   assign bw   = iw[6];
   assign aop  = f1 ? iw[15:12] : {1'h0, f2op};
   assign stack_op = f2 && (f2op >= cpu_pkg::F2_PUSH);
   // R2 with indirect modes and R3 in every mode yield constants, never memory
   assign cg   = (sreg == cpu_pkg::CG_IDX) || (sreg == cpu_pkg::SR_IDX && am[1]); // [RULE2]
   always_comb begin
      cgv = cpu_pkg::CG_ZERO;
      if (sreg == cpu_pkg::SR_IDX) begin
         cgv = am[0] ? cpu_pkg::CG_EIGHT : cpu_pkg::CG_FOUR;
      end else begin
         unique case (am)
            cpu_pkg::AM_REG: cgv = cpu_pkg::CG_ZERO;
            cpu_pkg::AM_IDX: cgv = cpu_pkg::CG_ONE;
            cpu_pkg::AM_IND: cgv = cpu_pkg::CG_TWO;
            cpu_pkg::AM_INC: cgv = cpu_pkg::CG_ONES;
         endcase
      end
   end
   assign needs_sext = (am == cpu_pkg::AM_IDX && sreg != cpu_pkg::CG_IDX) ||
                       (am == cpu_pkg::AM_INC && sreg == cpu_pkg::PC_IDX); // [RULE4]
   assign src_reg = (am == cpu_pkg::AM_REG) || cg;
   assign rv      = cg ? cgv : msk(rf_q[sreg], bw);
   // Indexed base: PC means the extension word's own address, R2 means absolute
   assign sbase = (sreg == cpu_pkg::PC_IDX) ? pc - cpu_pkg::WORD_STEP :
                  (sreg == cpu_pkg::SR_IDX) ? 16'h0000 : rf_q[sreg]; // [RULE10]
   assign dbase = (iw[3:0] == cpu_pkg::PC_IDX) ? pc - cpu_pkg::WORD_STEP :
                  (iw[3:0] == cpu_pkg::SR_IDX) ? 16'h0000 : rf_q[iw[3:0]];
   assign step  = (bw && sreg > cpu_pkg::SP_IDX) ? cpu_pkg::BYTE_STEP : cpu_pkg::WORD_STEP;
   assign rr_now = (f1 && src_reg && !ad) || (f2 && src_reg && !stack_op); // [RULE3]
   assign dec_src_rd = (st_q == cpu_pkg::st_decode) && !illegal && !jmp && !rr_now &&
                       !(f2 && f2op == cpu_pkg::F2_RETI) && !needs_sext && !src_reg;
   assign jmp_tgt = pc + {{5{iw[9]}}, iw[9:0], 1'h0};
   always_comb begin
      unique case (cpu_pkg::jump_cond_e'(iw[12:10]))
         cpu_pkg::jump_if_not_equal: take = !rf_q[cpu_pkg::SR_IDX][cpu_pkg::Z_BIT]; // [RULE9]
         cpu_pkg::jump_if_equal:     take = rf_q[cpu_pkg::SR_IDX][cpu_pkg::Z_BIT];
         cpu_pkg::jump_if_no_carry:  take = !rf_q[cpu_pkg::SR_IDX][cpu_pkg::C_BIT];
         cpu_pkg::jump_if_carry:     take = rf_q[cpu_pkg::SR_IDX][cpu_pkg::C_BIT];
         cpu_pkg::jump_if_negative:  take = rf_q[cpu_pkg::SR_IDX][cpu_pkg::N_BIT];
         cpu_pkg::jump_if_ge:        take = !(rf_q[cpu_pkg::SR_IDX][cpu_pkg::N_BIT] ^
                                              rf_q[cpu_pkg::SR_IDX][cpu_pkg::V_BIT]);
         cpu_pkg::jump_if_less:      take = rf_q[cpu_pkg::SR_IDX][cpu_pkg::N_BIT] ^
                                            rf_q[cpu_pkg::SR_IDX][cpu_pkg::V_BIT];
         cpu_pkg::jump_always:       take = 1'h1;
      endcase
   end
   assign alu_s = (st_q == cpu_pkg::st_decode) ? rv : sv_q;
   assign alu_d = !f1 ? alu_s : (st_q != cpu_pkg::st_decode && dmem_q) ? dv_q :
                  msk(rf_q[iw[3:0]], bw);
   assign alu_r = alu(aop, bw, alu_s, alu_d, rf_q[cpu_pkg::SR_IDX][cpu_pkg::C_BIT]);
   assign dst_is_reg = f1 ? !ad : (am == cpu_pkg::AM_REG);
   assign exec_now = (st_q == cpu_pkg::st_decode && rr_now) ||
                     (st_q == cpu_pkg::st_exec && !stack_op);
   assign wb_en = exec_now && alu_r.wr && dst_is_reg && iw[3:0] != cpu_pkg::CG_IDX;
   assign mem_wr_now = st_q == cpu_pkg::st_exec && alu_r.wr && !dst_is_reg && dmem_q &&
                       !stack_op;
   assign cpu_status_word_q = rf_q[cpu_pkg::SR_IDX];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q      <= cpu_pkg::st_vec;
         mem_req_q <= '0;
         retire_q  <= 1'h0;
         ir_q      <= '0;
         sv_q      <= '0;
         dv_q      <= '0;
         da_q      <= '0;
         dmem_q    <= 1'h0;
         for (int i = 0; i < cpu_pkg::NUM_REGS; i++) begin
            rf_q[i] <= '0;
         end
      end else begin
         mem_req_q.rd <= 1'h0;
         mem_req_q.wr <= 1'h0;
         retire_q     <= 1'h0;
         if (exec_now && alu_r.fl) begin
            rf_q[cpu_pkg::SR_IDX][cpu_pkg::C_BIT] <= alu_r.c;
            rf_q[cpu_pkg::SR_IDX][cpu_pkg::Z_BIT] <= alu_r.z;
            rf_q[cpu_pkg::SR_IDX][cpu_pkg::N_BIT] <= alu_r.n;
            rf_q[cpu_pkg::SR_IDX][cpu_pkg::V_BIT] <= alu_r.v;
         end
         // An explicit write to R2 overrides the flags set above
         if (wb_en) begin
            rf_q[iw[3:0]] <= alu_r.res; // [RULE1] [RULE3]
         end
         unique case (st_q)
            cpu_pkg::st_vec: begin
               mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: 1'h0, addr: RESET_VEC, wdata: '0};
               st_q <= cpu_pkg::st_vload;
            end
            cpu_pkg::st_vload: begin
               rf_q[cpu_pkg::PC_IDX] <= mem_rdata;
               st_q <= cpu_pkg::st_fetch;
            end
            cpu_pkg::st_fetch: begin
               mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: 1'h0, addr: pc, wdata: '0}; // [RULE11]
               rf_q[cpu_pkg::PC_IDX] <= pc + cpu_pkg::WORD_STEP;
               st_q <= cpu_pkg::st_decode;
            end
            cpu_pkg::st_decode: begin
               ir_q   <= mem_rdata;
               dmem_q <= 1'h0;
               if (illegal || rr_now || jmp) begin
                  if (jmp && take) begin
                     rf_q[cpu_pkg::PC_IDX] <= jmp_tgt; // [RULE9]
                  end
                  retire_q <= 1'h1;
                  st_q <= cpu_pkg::st_fetch;
               end else if (f2 && f2op == cpu_pkg::F2_RETI) begin
                  mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: 1'h0,
                                 addr: rf_q[cpu_pkg::SP_IDX], wdata: '0};
                  rf_q[cpu_pkg::SP_IDX] <= rf_q[cpu_pkg::SP_IDX] + cpu_pkg::WORD_STEP; // [RULE12]
                  st_q <= cpu_pkg::st_pop_sr;
               end else if (needs_sext) begin
                  mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: 1'h0, addr: pc, wdata: '0};
                  rf_q[cpu_pkg::PC_IDX] <= pc + cpu_pkg::WORD_STEP;
                  st_q <= cpu_pkg::st_sext;
               end else if (src_reg) begin
                  sv_q <= rv;
                  st_q <= cpu_pkg::st_dph;
               end else begin
                  mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: bw, addr: rf_q[sreg], wdata: '0};
                  da_q   <= rf_q[sreg];
                  dmem_q <= f2;
                  if (am == cpu_pkg::AM_INC) begin
                     rf_q[sreg] <= rf_q[sreg] + step; // [RULE10]
                  end
                  st_q <= cpu_pkg::st_sread;
               end
            end
            cpu_pkg::st_sext: begin
               if (am == cpu_pkg::AM_INC) begin
                  sv_q <= msk(mem_rdata, bw);
                  st_q <= cpu_pkg::st_dph;
               end else begin
                  mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: bw, addr: mem_rdata + sbase,
                                 wdata: '0};
                  da_q   <= mem_rdata + sbase;
                  dmem_q <= f2;
                  st_q   <= cpu_pkg::st_sread;
               end
            end
            cpu_pkg::st_sread: begin
               sv_q <= msk(mem_rdata, bw);
               st_q <= cpu_pkg::st_dph;
            end
            cpu_pkg::st_dph: begin
               if (f1) begin
                  dmem_q <= ad;
               end
               if (f1 && ad) begin
                  mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: 1'h0, addr: pc, wdata: '0};
                  rf_q[cpu_pkg::PC_IDX] <= pc + cpu_pkg::WORD_STEP;
                  st_q <= cpu_pkg::st_dext;
               end else begin
                  st_q <= cpu_pkg::st_exec;
               end
            end
            cpu_pkg::st_dext: begin
               mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: bw, addr: mem_rdata + dbase, wdata: '0};
               da_q <= mem_rdata + dbase;
               st_q <= cpu_pkg::st_dread;
            end
            cpu_pkg::st_dread: begin
               dv_q <= msk(mem_rdata, bw);
               st_q <= cpu_pkg::st_exec;
            end
            cpu_pkg::st_exec: begin
               retire_q <= 1'h1;
               st_q <= cpu_pkg::st_fetch;
               if (stack_op) begin
                  rf_q[cpu_pkg::SP_IDX] <= rf_q[cpu_pkg::SP_IDX] - cpu_pkg::WORD_STEP; // [RULE12]
                  mem_req_q <= '{rd: 1'h0, wr: 1'h1, byte_en: bw && f2op == cpu_pkg::F2_PUSH,
                                 addr: rf_q[cpu_pkg::SP_IDX] - cpu_pkg::WORD_STEP,
                                 wdata: (f2op == cpu_pkg::F2_CALL) ? pc : sv_q};
                  if (f2op == cpu_pkg::F2_CALL) begin
                     rf_q[cpu_pkg::PC_IDX] <= sv_q; // [RULE8]
                  end
               end else if (mem_wr_now) begin
                  mem_req_q <= '{rd: 1'h0, wr: 1'h1, byte_en: bw, addr: da_q,
                                 wdata: alu_r.res}; // [RULE7]
               end
            end
            cpu_pkg::st_pop_sr: begin
               rf_q[cpu_pkg::SR_IDX] <= mem_rdata;
               mem_req_q <= '{rd: 1'h1, wr: 1'h0, byte_en: 1'h0,
                              addr: rf_q[cpu_pkg::SP_IDX], wdata: '0};
               rf_q[cpu_pkg::SP_IDX] <= rf_q[cpu_pkg::SP_IDX] + cpu_pkg::WORD_STEP;
               st_q <= cpu_pkg::st_pop_pc;
            end
            cpu_pkg::st_pop_pc: begin
               rf_q[cpu_pkg::PC_IDX] <= mem_rdata;
               retire_q <= 1'h1;
               st_q <= cpu_pkg::st_fetch;
            end
            default: st_q <= cpu_pkg::st_fetch;
         endcase
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_cg_never_written: assert property (rf_q[cpu_pkg::CG_IDX] == 16'h0000) // [RULE2]
      else $error("constant register was written");
   a_reg_op_one: assert property (st_q == cpu_pkg::st_decode && rr_now |=> // [RULE3]
      retire_q && st_q == cpu_pkg::st_fetch) else $error("reg op took more than one cycle");
   a_byte_high_clear: assert property (st_q == cpu_pkg::st_decode && wb_en && bw |=> // [RULE6]
      rf_q[$past(iw[3:0])][15:8] == 8'h00) else $error("byte result left high byte");
   a_call_push_pc: assert property (st_q == cpu_pkg::st_exec && f2 && // [RULE8]
      f2op == cpu_pkg::F2_CALL |=> mem_req_q.wr && mem_req_q.wdata == $past(pc) &&
      mem_req_q.addr == $past(rf_q[cpu_pkg::SP_IDX]) - cpu_pkg::WORD_STEP && pc == $past(sv_q))
      else $error("call did not push pc and load target");
   a_sp_push_step: assert property (st_q == cpu_pkg::st_exec && stack_op |=> // [RULE12]
      rf_q[cpu_pkg::SP_IDX] == $past(rf_q[cpu_pkg::SP_IDX]) - cpu_pkg::WORD_STEP)
      else $error("stack pointer not predecremented by two");
   a_jne_taken: assert property (st_q == cpu_pkg::st_decode && jmp && iw[12:10] == 3'h0 && // [RULE9]
      !rf_q[cpu_pkg::SR_IDX][cpu_pkg::Z_BIT] |=> pc == $past(jmp_tgt))
      else $error("not-equal jump not taken");
   a_jne_fall: assert property (st_q == cpu_pkg::st_decode && jmp && iw[12:10] == 3'h0 && // [RULE9]
      rf_q[cpu_pkg::SR_IDX][cpu_pkg::Z_BIT] |=> pc == $past(pc)) else $error("jump taken on equal");
   a_autoinc_word: assert property (dec_src_rd && am == cpu_pkg::AM_INC && !bw |=> // [RULE10]
      rf_q[$past(sreg)] == $past(rf_q[sreg]) + cpu_pkg::WORD_STEP)
      else $error("autoincrement step wrong");
   a_fetch_from_pc: assert property (st_q == cpu_pkg::st_fetch |=> mem_req_q.rd && // [RULE11]
      !mem_req_q.byte_en && mem_req_q.addr == $past(pc) && st_q == cpu_pkg::st_decode)
      else $error("fetch not issued at pc");
   a_dst_mem_write: assert property (mem_wr_now |=> mem_req_q.wr && // [RULE7]
      mem_req_q.addr == $past(da_q) && mem_req_q.wdata == $past(alu_r.res))
      else $error("memory destination not written");
   c_jump_taken: cover property (st_q == cpu_pkg::st_decode && jmp && take);
   c_call: cover property (st_q == cpu_pkg::st_exec && f2 && f2op == cpu_pkg::F2_CALL);
   c_byte_reg_op: cover property (st_q == cpu_pkg::st_decode && rr_now && bw);
   c_autoinc: cover property (dec_src_rd && am == cpu_pkg::AM_INC);
endmodule
`default_nettype wire

// ### tb/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input  wire logic              clk,
   input  wire cpu_pkg::mem_req_s req,
   output var  logic [15:0]       rdata
);
   logic [15:0] mem [0:32767];
   logic [15:0] rd_now;
   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
   end
   // Data stands while the strobe stands; the core takes it at the strobe's last edge
   assign rd_now = (req.byte_en && req.addr[0]) ? {8'h00, mem[req.addr[15:1]][15:8]}
                                                : mem[req.addr[15:1]];
   always @(posedge clk) begin
      if (req.wr && req.byte_en && req.addr[0]) mem[req.addr[15:1]][15:8] <= req.wdata[7:0];
      else if (req.wr && req.byte_en) mem[req.addr[15:1]][7:0] <= req.wdata[7:0];
      else if (req.wr) mem[req.addr[15:1]] <= req.wdata;
   end
   // Released bus shows the inverse so a late sample cannot pass by luck
   assign rdata = req.rd ? rd_now : ~rd_now;
endmodule
`default_nettype wire

// ### tb/risc16_cpu_operand_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
module risc16_cpu_operand_decode_bench;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
      logic [15:0] mask;
      logic        be;
   } note_s;
   logic              clk;
   logic              sys_rst;
   logic [15:0]       rdata;
   cpu_pkg::mem_req_s mem_req;
   logic              retire;
   logic [15:0]       status;
   note_s             q [$];
   note_s             n;
   logic [15:0]       seed;
   logic [15:0]       pc;
   logic [15:0]       x;
   logic [15:0]       y;
   logic [15:0]       exp_sr;
   int                n_ret;
   int                err_count;
   int                n_tests;
   risc16_cpu_operand_decode DUT (.clk(clk), .sys_rst(sys_rst), .mem_rdata(rdata),
      .mem_req_q(mem_req), .retire_q(retire), .cpu_status_word_q(status));
   mem_model mem_u (.clk(clk), .req(mem_req), .rdata(rdata));
   initial clk = 1'b0;
   always #25 clk = ~clk;
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 7);
      seed = seed ^ (seed >> 9);
      seed = seed ^ (seed << 8);
      return seed;
   endfunction
   task automatic emit(input logic [15:0] w);
      mem_u.mem[pc[15:1]] = w;
      pc = pc + 16'h0002;
   endtask
   task automatic note(input logic [15:0] a, input logic [15:0] d, input logic [15:0] m,
                       input logic be);
      q.push_back('{a, d, m, be});
   endtask
   task automatic check16(input string what, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check1(input string what, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Each bus write is matched against the oldest expected write
   always @(posedge clk) begin
      if (sys_rst === 1'b0 && retire === 1'b1) n_ret++;
      if (sys_rst === 1'b0 && mem_req.wr === 1'b1) begin
         if (q.size() == 0) begin
            err_count++;
            $display("MISMATCH write_addr expected none seen %h", mem_req.addr);
         end else begin
            n = q.pop_front();
            check16("write_addr", n.addr, mem_req.addr);
            check16("write_data", n.data & n.mask, mem_req.wdata & n.mask);
            check1("byte_en", n.be, mem_req.byte_en);
            check1("retire_with_write", 1'b1, retire);
            if (q.size() == 0) check16("retired", 16'h0013, 16'(n_ret));
         end
      end
   end
   // Program runs about 110 cycles; the limit leaves wide margin
   initial begin
      #(3000 * 50);
      err_count++;
      give_verdict();
   end
   initial begin
      sys_rst = 1'b1;
      err_count = 0;
      n_tests = 0;
      n_ret = 0;
      seed = 16'h0027;
      pc = 16'h4000;
      x = rnd();
      y = rnd() | 16'h0001;
      #1;
      mem_u.mem[15'h7fff] = 16'h4000;
      emit(16'h4031); emit(16'h0300);
      emit(16'h4034); emit(x); emit(16'h4035); emit(y); emit(16'h5405);
      emit(16'h4582); emit(16'h0200); note(16'h0200, x + y, 16'hffff, 1'b0);
      emit(16'h45c2); emit(16'h0202); note(16'h0202, x + y, 16'h00ff, 1'b1);
      emit(16'h9404); emit(16'h4282); emit(16'h020e);
      note(16'h020e, 16'h0001 << cpu_pkg::Z_BIT, 16'h0001 << cpu_pkg::Z_BIT, 1'b0);
      emit(16'h2002); emit(16'h4482); emit(16'h0204); note(16'h0204, x, 16'hffff, 1'b0);
      // Taken jump must skip the write to 0x0206
      emit(16'h9405); emit(16'h2002); emit(16'h4482); emit(16'h0206);
      emit(16'h403a); emit(16'h0200); emit(16'h4a3b);
      emit(16'h4a82); emit(16'h0208); note(16'h0208, 16'h0202, 16'hffff, 1'b0);
      emit(16'h4b82); emit(16'h020a); note(16'h020a, x + y, 16'hffff, 1'b0);
      emit(16'h4038); emit(16'h4100); emit(16'h1288);
      note(16'h02fe, pc, 16'hffff, 1'b0);
      pc = 16'h4100;
      emit(16'h4182); emit(16'h020c); note(16'h020c, 16'h02fe, 16'hffff, 1'b0);
      emit(16'h3fff);
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'b0;
      for (int i = 0; i < 400 && q.size() != 0; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      check16("pending_writes", 16'h0000, 16'(q.size()));
      // Last flag change is the compare of x+y against x: result y, borrow when x+y wraps
      exp_sr = {13'h0000, y[15], 1'b0, (({1'b0, x} + {1'b0, y}) < 17'h10000)};
      check16("status_flags", exp_sr, status & 16'h0007);
      give_verdict();
   end
endmodule
`default_nettype wire
